/* bench/efd_host_sink.sv */
`timescale 1ns/1ps
// ==========================================================
// host memory side of the extra dma link
module efd_host_sink (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dma_valid,
  input wire logic [31:0] dma_data,
  input wire logic hold,
  output logic dma_ready,
  output logic got,
  output logic [31:0] got_word
);
  logic [1:0] cnt_q;
  // memory takes a word every other cycle, none while held
  always @(posedge clk) begin
    cnt_q <= resetn ? cnt_q + 2'h1 : 2'h0;
    got <= resetn && dma_valid && dma_ready;
    got_word <= dma_data;
  end
  assign dma_ready = !hold && cnt_q[0];
endmodule

/* bench/tb_extra_fifo_dma_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_extra_fifo_dma_control;
  import efd_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid, buf_defined, aba_valid, refclk_pin;
  logic dma_valid, dma_ready, ctl_stb, wait_busy, wait_expired, hold, got, ts_trigger, dma_err;
  logic [15:0] reg_addr, wait_timeout_ms;
  logic [23:0] buf_words, notify_words;
  logic [31:0] reg_wdata, reg_rdata, card_flags_in, aba_data, pc_time, pc_date;
  logic [31:0] dma_data, ctl, got_word, d, e, t0;
  logic [31:0] seed = 32'h1bfb924f;
  logic [31:0] q[$];
  int err_count = 0;
  int n_compared = 0;
  int i;
  efd_extra_dma #(.P_CYC_PER_MS(8)) dut_u (.clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .buf_defined, .buf_words, .notify_words,
    .wait_timeout_ms, .card_flags_in, .card_ctl_cmd(ctl), .card_ctl_stb(ctl_stb),
    .aba_valid, .aba_data, .ts_trigger, .refclk_pin, .pc_time, .pc_date,
    .dma_valid, .dma_data, .dma_ready, .dma_err, .wait_busy, .wait_expired);
  efd_host_sink host_u (.clk, .resetn, .dma_valid, .dma_data, .hold, .dma_ready, .got,
    .got_word);
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic expire();
    err_count++;
    conclude();
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] v);
    tick();
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    tick();
    reg_wr = 0;
  endtask
  task automatic rd(logic [15:0] a, output logic [31:0] v);
    int k;
    tick();
    reg_rd = 1;
    reg_addr = a;
    tick();
    reg_rd = 0;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) tick();
    if (k == 4) expire();
    v = reg_rdata;
  endtask
  task automatic stat(logic [31:0] x);
    rd(REG_CARD_STATUS, d);
    `CHK(d, card_flags_in | x)
  endtask
  task automatic push(int n);
    for (int k = 0; k < n; k++) begin
      tick();
      aba_valid = 1;
      aba_data = rnd();
      q.push_back(aba_data);
    end
    tick();
    aba_valid = 0;
  endtask
  task automatic drain();
    for (int k = 0; k < 300 && q.size() > 0; k++) begin
      tick();
      if (got === 1'b1) begin
        e = q.pop_front();
        `CHK(got_word, e)
      end
    end
    if (q.size() > 0) expire();
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    expire();
  end
  // ==========================================================
  // main sequence
  initial begin
    {resetn, reg_wr, reg_rd, aba_valid, refclk_pin, hold, ts_trigger, dma_err} = '0;
    {reg_addr, reg_wdata, aba_data, wait_timeout_ms, notify_words} = '0;
    buf_defined = 1;
    buf_words = 24'h4;
    card_flags_in = rnd() & 32'hffff0fff;
    pc_time = rnd();
    pc_date = rnd();
    repeat (6) tick();
    resetn = 1;
    stat(0);
    rd(REG_CARD_COMMAND, d);
    `CHK(d, 32'h0)
    rd(16'h0065, d);
    `CHK(d, 32'h0)
    wr(REG_CARD_STATUS, 32'hffffffff);
    stat(0);
    $display("test registers done");
    push(4);
    wr(REG_CARD_COMMAND, 32'h0010_0005);
    `CHK(ctl_stb, 1'b1)
    `CHK(ctl, 32'h5)
    drain();
    stat(32'h2000);
    notify_words = 24'h2;
    push(4);
    wr(REG_CARD_COMMAND, 32'h0010_0000);
    drain();
    stat(32'h1000);
    hold = 1;
    push(2);
    wr(REG_CARD_COMMAND, 32'h0040_0000);
    hold = 0;
    q.delete();
    for (i = 0; i < 20 && got !== 1'b1; i++) tick();
    `CHK(i, 20)
    $display("test dma done");
    buf_defined = 0;
    wr(REG_CARD_COMMAND, 32'h0010_0000);
    stat(32'h8000);
    buf_defined = 1;
    wr(REG_CARD_COMMAND, 32'h0090_0000);
    stat(32'h8000);
    wr(REG_CARD_COMMAND, 32'h0040_0000);
    push(3);
    wr(REG_CARD_COMMAND, 32'h0080_0000);
    for (i = 0; i < 4; i++) begin
      rd(REG_POLL_DATA, d);
      e = (i < 3) ? q.pop_front() : 32'h0;
      `CHK(d, e)
    end
    $display("test poll done");
    wr(REG_CARD_COMMAND, 32'h0040_0000);
    wait_timeout_ms = 16'h1;
    wr(REG_CARD_COMMAND, 32'h0030_0000);
    `CHK(wait_busy, 1'b1)
    for (i = 0; i < 40 && wait_busy === 1'b1; i++) tick();
    `CHK(wait_expired, 1'b1)
    $display("test wait done");
    wr(REG_TS_TIMEOUT, 32'h3);
    wr(REG_TS_CMD, 32'h202);
    wr(REG_TS_CMD, 32'h203);
    tick();
    refclk_pin = 1;
    for (i = 0; i < 10 && (i == 0 || d[0] !== 1'b0); i++) rd(REG_TS_SYNC_STAT, d);
    `CHK(d, 32'h0)
    rd(REG_TS_TIME, d);
    `CHK(d, pc_time)
    rd(REG_TS_DATE, d);
    `CHK(d, pc_date)
    t0 = pc_time;
    pc_time = rnd();
    wr(REG_TS_CMD, 32'h203);
    for (i = 0; i < 30 && (i == 0 || d[0] !== 1'b0); i++) rd(REG_TS_SYNC_STAT, d);
    `CHK(d, 32'h2)
    rd(REG_TS_TIME, d);
    `CHK(d, t0)
    // falling reference edge mode captures the new host time
    wr(REG_TS_CMD, 32'h403);
    tick();
    refclk_pin = 0;
    for (i = 0; i < 10 && (i == 0 || d[0] !== 1'b0); i++) rd(REG_TS_SYNC_STAT, d);
    `CHK(d, 32'h0)
    rd(REG_TS_TIME, d);
    `CHK(d, pc_time)
    $display("test sync done");
    // two stamps three cycles apart, read back by polling
    wr(REG_CARD_COMMAND, 32'h0040_0000);
    wr(REG_CARD_COMMAND, 32'h0080_0000);
    repeat (2) begin
      tick();
      ts_trigger = 1;
      tick();
      ts_trigger = 0;
      tick();
    end
    rd(REG_POLL_DATA, e);
    for (i = 0; i < 3; i++) begin
      rd(REG_POLL_DATA, d);
      `CHK(d - ((i == 1) ? e : 32'h0), (i == 1) ? 32'h3 : 32'h0)
    end
    // filling the fifo past its depth halts polling
    push(65);
    q.delete();
    stat(32'h4000);
    rd(REG_POLL_DATA, d);
    `CHK(d, 32'h0)
    // a bus fault during dma raises the error flag
    wr(REG_CARD_COMMAND, 32'h0040_0000);
    wr(REG_CARD_COMMAND, 32'h0010_0000);
    tick();
    dma_err = 1;
    tick();
    dma_err = 0;
    stat(32'h8000);
    $display("test stamp done");
    conclude();
  end
endmodule

/* src/efd_extra_dma.sv */
`timescale 1ns/1ps
// ==========================================================
module efd_extra_dma #(
  parameter int DEPTH = 64,
  parameter int WC = 24,
  parameter int P_CYC_PER_MS = efd_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [efd_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic buf_defined,
  input wire logic [WC-1:0] buf_words,
  input wire logic [WC-1:0] notify_words,
  input wire logic [15:0] wait_timeout_ms,
  input wire logic [31:0] card_flags_in,
  output logic [31:0] card_ctl_cmd,
  output logic card_ctl_stb,
  input wire logic aba_valid,
  input wire logic [31:0] aba_data,
  input wire logic ts_trigger,
  input wire logic refclk_pin,
  input wire logic [31:0] pc_time,
  input wire logic [31:0] pc_date,
  output logic dma_valid,
  output logic [31:0] dma_data,
  input wire logic dma_ready,
  input wire logic dma_err,
  output logic wait_busy,
  output logic wait_expired
);
  import efd_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(P_CYC_PER_MS);
  typedef struct packed {
    efd_ex_state_t st;
    logic [AW:0] cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic fetch;
    logic dv;
    logic [31:0] dd;
    logic [WC-1:0] done_w;
    logic [WC-1:0] blk_w;
    logic f_blk;
    logic f_end;
    logic f_ovr;
    logic f_err;
    logic ts_pend;
    logic [31:0] ts_hi;
    logic rd_pend;
    logic [15:0] rd_addr;
    logic rd_pop;
    logic [31:0] rdata;
    logic rv;
    logic [31:0] ctl;
    logic ctl_stb;
    logic wbusy;
    logic wexp;
    logic [15:0] wms;
    logic [CW-1:0] wpre;
    logic [31:0] ts_mode;
    logic [15:0] ts_tmo;
    logic ts_rst;
  } efd_state_t;
  efd_state_t s_q, s_d;

  logic cmd_wr, c_start, c_wait, c_stop, c_poll;
  logic full, ts_on, push_req, we, pop;
  logic set_blk, set_end, set_ovr, set_err, clr_run, clr_blk;
  logic [31:0] push_data, mem_rdata, stat_word;
  logic [31:0] ts_hi, ts_lo, cap_time, cap_date;
  logic ts_busy, ts_tmo_flag;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end
  if (P_CYC_PER_MS < 2 || WC < 2) begin : g_bad_counts
    $error("count widths too small");
  end

  // ==========================================================
  // command decode, a stop in one write masks the start and poll of that write
  assign cmd_wr = reg_wr && (reg_addr == REG_CARD_COMMAND);
  assign c_start = cmd_wr && reg_wdata[CMD_START_BIT];
  assign c_wait = cmd_wr && reg_wdata[CMD_WAIT_BIT];
  assign c_stop = cmd_wr && reg_wdata[CMD_STOP_BIT];
  assign c_poll = cmd_wr && reg_wdata[CMD_POLL_BIT];
  assign full = s_q.cnt[AW];
  assign ts_on = s_q.ts_mode != '0;

  // status word, one bit per flag
  always_comb begin
    stat_word = card_flags_in & ~STAT_EXTRA_MASK;
    stat_word[STAT_BLK_BIT] = s_q.f_blk;
    stat_word[STAT_END_BIT] = s_q.f_end;
    stat_word[STAT_OVR_BIT] = s_q.f_ovr;
    stat_word[STAT_ERR_BIT] = s_q.f_err;
  end

  // ==========================================================
  // timestamp counter and reference clock sync
  efd_ts_sync #(
    .CYC_PER_MS(P_CYC_PER_MS)
  ) u_ts (
    .clk(clk),
    .resetn(resetn),
    .refclk_pin(refclk_pin),
    .mode(s_q.ts_mode),
    .reset_req(s_q.ts_rst),
    .timeout_ms(s_q.ts_tmo),
    .pc_time(pc_time),
    .pc_date(pc_date),
    .count_hi(ts_hi),
    .count_lo(ts_lo),
    .busy(ts_busy),
    .timed_out(ts_tmo_flag),
    .cap_time(cap_time),
    .cap_date(cap_date)
  );

  // extra fifo storage
  efd_xfifo_mem #(
    .W(32),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .resetn(resetn),
    .we(we),
    .waddr(s_q.wp),
    .wdata(push_data),
    .raddr(s_q.rp),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // main next-state process
  always_comb begin
    s_d = s_q;
    s_d.ctl_stb = 1'b0;
    s_d.rv = 1'b0;
    s_d.rd_pend = 1'b0;
    s_d.rd_pop = 1'b0;
    s_d.ts_rst = 1'b0;
    push_req = 1'b0;
    push_data = '0;
    pop = 1'b0;
    set_blk = 1'b0;
    set_end = 1'b0;
    set_ovr = 1'b0;
    set_err = 1'b0;
    clr_run = 1'b0;
    clr_blk = 1'b0;

    // fifo fill: high half of a stamp, new stamp, then slow-side data
    if (s_q.ts_pend) begin
      push_req = 1'b1;
      push_data = s_q.ts_hi;
      s_d.ts_pend = 1'b0;
      set_ovr = (ts_trigger && ts_on) || aba_valid; // word lost
    end else if (ts_trigger && ts_on) begin
      push_req = 1'b1;
      push_data = ts_lo;
      s_d.ts_pend = 1'b1;
      s_d.ts_hi = ts_hi;
      set_ovr = aba_valid;
    end else if (aba_valid) begin
      push_req = 1'b1;
      push_data = aba_data;
    end
    if (push_req && full) begin
      set_ovr = 1'b1;
    end

    // extra transfer engine
    unique case (s_q.st)
      EX_IDLE, EX_HALT: begin
      end
      EX_DMA: begin
        if (s_q.dv && dma_ready) begin
          s_d.dv = 1'b0;
          s_d.done_w = s_q.done_w + WC'(1);
          s_d.blk_w = s_q.blk_w + WC'(1);
          if (notify_words != '0 && s_q.blk_w + WC'(1) == notify_words) begin
            set_blk = 1'b1;
            s_d.blk_w = '0;
          end
          if (notify_words == '0 && s_q.done_w + WC'(1) == buf_words) begin
            set_end = 1'b1;
            s_d.st = EX_HALT;
          end
        end
        if (s_q.fetch) begin
          s_d.fetch = 1'b0;
          s_d.dv = 1'b1;
          s_d.dd = mem_rdata;
        end else if (!s_q.dv && s_q.cnt != '0) begin
          s_d.fetch = 1'b1;
          pop = 1'b1;
        end
        if (dma_err) begin
          set_err = 1'b1;
          s_d.st = EX_HALT;
          s_d.dv = 1'b0;
          s_d.fetch = 1'b0;
        end
      end
      EX_POLL: begin
      end
    endcase

    // register reads answer two cycles after the strobe
    if (reg_rd) begin
      s_d.rd_pend = 1'b1;
      s_d.rd_addr = reg_addr;
      if (reg_addr == REG_POLL_DATA && s_q.st == EX_POLL && s_q.cnt != '0) begin
        s_d.rd_pop = 1'b1;
        pop = 1'b1;
      end
    end
    if (s_q.rd_pend) begin
      s_d.rv = 1'b1;
      unique case (s_q.rd_addr)
        REG_CARD_STATUS: begin
          s_d.rdata = stat_word;
          clr_blk = 1'b1;
        end
        REG_TS_CMD: s_d.rdata = s_q.ts_mode;
        REG_TS_TIME: s_d.rdata = cap_time;
        REG_TS_DATE: s_d.rdata = cap_date;
        REG_TS_TIMEOUT: s_d.rdata = {16'h0000, s_q.ts_tmo};
        REG_TS_SYNC_STAT: s_d.rdata = {30'h0, ts_tmo_flag, ts_busy};
        REG_POLL_DATA: s_d.rdata = s_q.rd_pop ? mem_rdata : 32'h0;
        default: s_d.rdata = 32'h0; // command register reads as zero
      endcase
    end

    // register writes
    if (cmd_wr) begin
      s_d.ctl = reg_wdata & ~CMD_EXTRA_MASK;
      s_d.ctl_stb = 1'b1;
    end
    if (reg_wr && reg_addr == REG_TS_CMD) begin
      s_d.ts_mode = reg_wdata & TS_MODE_MASK;
      s_d.ts_rst = reg_wdata[TS_RESET_BIT];
    end
    if (reg_wr && reg_addr == REG_TS_TIMEOUT) begin
      s_d.ts_tmo = reg_wdata[15:0];
    end

    // extra commands: stop wins over start and poll
    if (c_stop) begin
      s_d.st = EX_IDLE;
      s_d.dv = 1'b0;
      s_d.fetch = 1'b0;
    end else if (c_start) begin
      if (!buf_defined || c_poll || s_q.st == EX_POLL) begin
        set_err = 1'b1;
      end else begin
        s_d.st = EX_DMA;
        s_d.done_w = '0;
        s_d.blk_w = '0;
        s_d.dv = 1'b0;
        s_d.fetch = 1'b0;
        clr_run = 1'b1;
      end
    end else if (c_poll) begin
      if (s_q.st == EX_DMA) begin
        set_err = 1'b1;
      end else begin
        s_d.st = EX_POLL;
        clr_run = 1'b1;
      end
    end

    // an overrun halts a running transfer at once
    if (set_ovr && (s_d.st == EX_DMA || s_d.st == EX_POLL)) begin
      s_d.st = EX_HALT;
      s_d.dv = 1'b0;
      s_d.fetch = 1'b0;
    end

    // sticky flags, a set in the clearing cycle wins
    s_d.f_blk = ((clr_run || clr_blk) ? 1'b0 : s_q.f_blk) | set_blk;
    s_d.f_end = (clr_run ? 1'b0 : s_q.f_end) | set_end;
    s_d.f_ovr = (clr_run ? 1'b0 : s_q.f_ovr) | set_ovr;
    s_d.f_err = (clr_run ? 1'b0 : s_q.f_err) | set_err;

    // fifo pointers, an abort throws away stored words
    we = push_req && !full && !c_stop;
    if (c_stop) begin
      s_d.rp = s_q.wp;
      s_d.cnt = '0;
    end else begin
      s_d.wp = s_q.wp + AW'(we);
      s_d.rp = s_q.rp + AW'(pop);
      s_d.cnt = s_q.cnt + (AW + 1)'(we) - (AW + 1)'(pop);
    end

    // wait command: block, end, fault, or millisecond timeout
    if (c_wait) begin
      s_d.wbusy = 1'b1;
      s_d.wexp = 1'b0;
      s_d.wms = '0;
      s_d.wpre = '0;
    end else if (s_q.wbusy) begin
      if (s_q.f_blk || s_q.f_end || s_q.f_ovr || s_q.f_err || s_q.st != EX_DMA) begin
        s_d.wbusy = 1'b0;
      end else if (wait_timeout_ms != '0) begin
        if (s_q.wpre == CW'(P_CYC_PER_MS - 1)) begin
          s_d.wpre = '0;
          s_d.wms = s_q.wms + 16'h1;
          if (s_q.wms + 16'h1 == wait_timeout_ms) begin
            s_d.wbusy = 1'b0;
            s_d.wexp = 1'b1;
          end
        end else begin
          s_d.wpre = s_q.wpre + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.ts_mode <= TS_MODE_RST;
      s_q.ts_tmo <= TS_TIMEOUT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rv;
  assign card_ctl_cmd = s_q.ctl;
  assign card_ctl_stb = s_q.ctl_stb;
  assign dma_valid = s_q.dv;
  assign dma_data = s_q.dd;
  assign wait_busy = s_q.wbusy;
  assign wait_expired = s_q.wexp;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_stop_flush;
    c_stop |=> s_q.st == EX_IDLE && s_q.cnt == '0 && !s_q.dv;
  endproperty
  a_stop_flush: assert property (p_stop_flush) else $error("stop did not abort");
  property p_ovr_halt;
    push_req && full && (s_q.st == EX_DMA || s_q.st == EX_POLL) && !c_stop
      |=> s_q.f_ovr && s_q.st == EX_HALT && !s_q.dv;
  endproperty
  a_ovr_halt: assert property (p_ovr_halt) else $error("overrun did not halt");
  property p_read_answer;
    reg_rd |-> ##2 reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_start_dma;
    c_start && !c_stop && !c_poll && buf_defined && s_q.st != EX_POLL && !set_ovr
      |=> s_q.st == EX_DMA && s_q.done_w == '0;
  endproperty
  a_start_dma: assert property (p_start_dma) else $error("start ignored");
  property p_end_zero_notify;
    $rose(s_q.f_end) |-> $past(notify_words) == '0;
  endproperty
  a_end_zero_notify: assert property (p_end_zero_notify) else $error("end with notify");
  property p_block_ready;
    s_q.st == EX_DMA && s_q.dv && dma_ready && !dma_err && !cmd_wr && notify_words != '0
      && s_q.blk_w + WC'(1) == notify_words |=> s_q.f_blk;
  endproperty
  a_block_ready: assert property (p_block_ready) else $error("block ready missed");
  property p_wait_release;
    s_q.wbusy && !c_wait && (s_q.f_blk || s_q.f_ovr) |=> !s_q.wbusy;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released");
  property p_ctl_forward;
    cmd_wr |=> card_ctl_stb && card_ctl_cmd == ($past(reg_wdata) & ~CMD_EXTRA_MASK);
  endproperty
  a_ctl_forward: assert property (p_ctl_forward) else $error("command not forwarded");
  c_dma_word: cover property (s_q.dv && dma_ready);
  c_wait_expire: cover property ($rose(s_q.wexp));
  c_poll_read: cover property (s_q.rd_pop ##1 reg_rvalid);
endmodule

/* src/efd_pkg.sv */
package efd_pkg;
  // ==========================================================
  // register numbers (word index on the register port)
  localparam int REG_AW = 16;
  localparam logic [15:0] REG_CARD_COMMAND = 16'h0064;
  localparam logic [15:0] REG_CARD_STATUS = 16'h006e;
  localparam logic [15:0] REG_TS_CMD = 16'hb798;
  localparam logic [15:0] REG_TS_TIME = 16'hb7b6;
  localparam logic [15:0] REG_TS_DATE = 16'hb7b7;
  localparam logic [15:0] REG_TS_TIMEOUT = 16'hb7c5;
  localparam logic [15:0] REG_POLL_DATA = 16'hb7fc;
  localparam logic [15:0] REG_TS_SYNC_STAT = 16'hb7fd;
  // ==========================================================
  // card_command bit positions
  localparam int CMD_START_BIT = 20;
  localparam int CMD_WAIT_BIT = 21;
  localparam int CMD_STOP_BIT = 22;
  localparam int CMD_POLL_BIT = 23;
  localparam logic [31:0] CMD_EXTRA_MASK = 32'h00f0_0000;
  // card_status bit positions
  localparam int STAT_BLK_BIT = 12;
  localparam int STAT_END_BIT = 13;
  localparam int STAT_OVR_BIT = 14;
  localparam int STAT_ERR_BIT = 15;
  localparam logic [31:0] STAT_EXTRA_MASK = 32'h0000_f000;
  // timestamp_command bits
  localparam int TS_RESET_BIT = 0;
  localparam int TS_REFPOS_BIT = 9;
  localparam int TS_REFNEG_BIT = 10;
  localparam logic [31:0] TS_MODE_MASK = 32'h0000_0606;
  // values after reset
  localparam logic [31:0] TS_MODE_RST = 32'h0000_0000;
  localparam logic [15:0] TS_TIMEOUT_RST = 16'h0000;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // ==========================================================
  // state encodings
  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_DMA = 2'b01,
    EX_POLL = 2'b10,
    EX_HALT = 2'b11
  } efd_ex_state_t;
  typedef enum logic {
    TS_IDLE = 1'b0,
    TS_WAIT = 1'b1
  } efd_ts_state_t;
endpackage

/* src/efd_ts_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// timestamp counter and reference clock synchronising reset
module efd_ts_sync #(
  parameter int CYC_PER_MS = 25000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic refclk_pin,
  input wire logic [31:0] mode,
  input wire logic reset_req,
  input wire logic [15:0] timeout_ms,
  input wire logic [31:0] pc_time,
  input wire logic [31:0] pc_date,
  output logic [31:0] count_hi,
  output logic [31:0] count_lo,
  output logic busy,
  output logic timed_out,
  output logic [31:0] cap_time,
  output logic [31:0] cap_date
);
  import efd_pkg::*;
  localparam int CW = $clog2(CYC_PER_MS);
  typedef struct packed {
    logic m1;
    logic m2;
    logic m3;
    efd_ts_state_t st;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [CW-1:0] pre;
    logic [15:0] ms;
    logic tmo;
    logic [31:0] ct;
    logic [31:0] cd;
  } efd_ts_reg_t;
  efd_ts_reg_t s_q, s_d;
  logic refmode, edge_hit, tick, tmo_hit;

  if (CYC_PER_MS < 2) begin : g_bad_ms
    $error("cycles per millisecond must be at least two");
  end

  // edge detect looks only at the second stage and its delay
  assign refmode = mode[TS_REFPOS_BIT] | mode[TS_REFNEG_BIT];
  assign edge_hit = (mode[TS_REFPOS_BIT] && s_q.m2 && !s_q.m3)
    || (mode[TS_REFNEG_BIT] && !s_q.m2 && s_q.m3);
  assign tick = s_q.pre == CW'(CYC_PER_MS - 1);
  assign tmo_hit = tick && (s_q.ms + 16'h0001 >= timeout_ms);

  // counting and the synchronising reset sequence
  always_comb begin
    s_d = s_q;
    s_d.m1 = refclk_pin;
    s_d.m2 = s_q.m1;
    s_d.m3 = s_q.m2;
    if (refmode) begin
      if (edge_hit) begin
        s_d.hi = s_q.hi + 32'h1;
        s_d.lo = '0;
      end else begin
        s_d.lo = s_q.lo + 32'h1;
      end
    end else if (mode != '0) begin
      {s_d.hi, s_d.lo} = {s_q.hi, s_q.lo} + 64'h1;
    end
    unique case (s_q.st)
      TS_IDLE: begin
        if (reset_req && refmode) begin
          s_d.st = TS_WAIT;
          s_d.pre = '0;
          s_d.ms = '0;
          s_d.tmo = 1'b0;
        end else if (reset_req) begin
          s_d.hi = '0;
          s_d.lo = '0;
          s_d.tmo = 1'b0;
        end
      end
      TS_WAIT: begin
        if (edge_hit) begin
          s_d.hi = '0;
          s_d.lo = '0;
          s_d.ct = pc_time;
          s_d.cd = pc_date;
          s_d.st = TS_IDLE;
        end else if (tmo_hit) begin
          s_d.tmo = 1'b1;
          s_d.st = TS_IDLE;
        end else if (tick) begin
          s_d.pre = '0;
          s_d.ms = s_q.ms + 16'h1;
        end else begin
          s_d.pre = s_q.pre + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_hi = s_q.hi;
  assign count_lo = s_q.lo;
  assign busy = s_q.st == TS_WAIT;
  assign timed_out = s_q.tmo;
  assign cap_time = s_q.ct;
  assign cap_date = s_q.cd;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_sync_capture;
    s_q.st == TS_WAIT && edge_hit |=> s_q.st == TS_IDLE && s_q.hi == '0 && s_q.lo == '0
      && s_q.ct == $past(pc_time);
  endproperty
  a_sync_capture: assert property (p_sync_capture) else $error("sync edge not captured");
  property p_timeout_no_capture;
    s_q.st == TS_WAIT && !edge_hit && tmo_hit |=> s_q.tmo && $stable(s_q.ct)
      && s_q.st == TS_IDLE;
  endproperty
  a_timeout_no_capture: assert property (p_timeout_no_capture) else $error("bad timeout");
  property p_wait_started;
    s_q.st == TS_IDLE && reset_req && refmode |=> s_q.st == TS_WAIT && !s_q.tmo;
  endproperty
  a_wait_started: assert property (p_wait_started) else $error("reset did not wait");
  c_sync_done: cover property (s_q.st == TS_WAIT ##1 s_q.st == TS_IDLE && !s_q.tmo);
endmodule

/* src/efd_xfifo_mem.sv */
`timescale 1ns/1ps
// ==========================================================
// extra fifo storage, registered read data
module efd_xfifo_mem #(
  parameter int W = 32,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } efd_mem_t;
  efd_mem_t m_q, m_d;

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("depth must equal two to the address width");
  end

  // write port and read register
  always_comb begin
    m_d = m_q;
    if (we) begin
      m_d.mem[waddr] = wdata;
    end
    m_d.rd = m_q.mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rdata = m_q.rd;
endmodule
